// File: hdl/asp_consts.svh
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// ----------------------------------------
// Register indices, byte address is index * 4.
// ----------------------------------------
`define ASP_IDX_DATA   4'h0
`define ASP_IDX_IER    4'h1
`define ASP_IDX_IIR    4'h2
`define ASP_IDX_LCR    4'h3
`define ASP_IDX_MCR    4'h4
`define ASP_IDX_LSR    4'h5
`define ASP_IDX_MSR    4'h6
`define ASP_IDX_SCR    4'h7
`define ASP_IDX_EVT    4'h8
`define ASP_IDX_EVM    4'h9

// ----------------------------------------
// Field positions.
// ----------------------------------------
`define ASP_LCR_STB    2
`define ASP_LCR_PEN    3
`define ASP_LCR_EPS    4
`define ASP_LCR_STICK  5
`define ASP_LCR_BRK    6
`define ASP_LCR_DIVISOR_SELECT_BIT   7
`define ASP_MCR_LOOP   4

// ----------------------------------------
// Reset values.
// ----------------------------------------
`define ASP_DIV_RST    16'h0001
`define ASP_REG_RST    8'h00

// ----------------------------------------
// Timing in 16x ticks.
// ----------------------------------------
`define ASP_TICK_BIT   6'h0f
`define ASP_TICK_HALF  6'h07
`define ASP_TICK_ST15  6'h17
`define ASP_TICK_ST2   6'h1f

// ----------------------------------------
// Interrupt identification codes.
// ----------------------------------------
`define ASP_ID_LINE    2'h3
`define ASP_ID_RXD     2'h2
`define ASP_ID_TX_HOLDING_EMPTY_FLAG    2'h1
`define ASP_ID_MODEM   2'h0

`endif

// File: hdl/asp_pkg.sv
package asp_pkg;

    typedef enum logic [4:0] {
        ASP_IDLE = 5'b00001,
        ASP_STRT = 5'b00010,
        ASP_DATA = 5'b00100,
        ASP_PAR  = 5'b01000,
        ASP_STOP = 5'b10000
    } asp_fsm_t;

    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } asp_modem_in_t;

    typedef struct packed {
        logic out2_n;
        logic out1_n;
        logic rts_n;
        logic dtr_n;
    } asp_modem_out_t;

    typedef struct packed {
        logic          ack;
        logic [7:0]    dat;
        logic [3:0]    irq_enable_mask;
        logic [7:0]    lcr;
        logic [4:0]    mcr;
        logic [7:0]    scr;
        logic [15:0]   div;
        logic [3:0]    evt;
        logic [3:0]    evm;
        logic [3:0]    src_q;
        logic [15:0]   baud_cnt;
        logic          tick;
        logic          rx_s1;
        logic          rx_s2;
        logic [3:0]    mdm_s1;
        logic [3:0]    mdm_s2;
        logic [3:0]    mdm_q;
        logic [3:0]    msr_d;
        logic [7:0]    transmit_holding;
        logic          tx_holding_empty_flag;
        logic          thri;
        asp_fsm_t      tx_st;
        logic [7:0]    tx_sh;
        logic [5:0]    tx_cnt;
        logic [2:0]    tx_bit;
        asp_fsm_t      rx_st;
        logic [7:0]    rx_sh;
        logic [5:0]    rx_cnt;
        logic [2:0]    rx_bit;
        logic          rx_par;
        logic          rx_zero;
        logic [7:0]    receive_buffer;
        logic          dr;
        logic          oe;
        logic          pe;
        logic          fe;
        logic          bi;
    } asp_state_t;

endpackage : asp_pkg

// File: hdl/asp_serial_port.sv
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ns
`include "asp_consts.svh"

module asp_serial_port
    import asp_pkg::*;
(
    input  wire logic           clk_sys_i,
    input  wire logic           rst_b_i,
    input  wire logic           wb_cyc_i,
    input  wire logic           wb_stb_i,
    input  wire logic           wb_we_i,
    input  wire logic [5:0]     wb_adr_i,
    input  wire logic [3:0]     wb_sel_i,
    input  wire logic [31:0]    wb_dat_i,
    output logic      [31:0]    wb_dat_o,
    output logic                wb_ack_o,
    input  wire logic           rx_i,
    output logic                tx_o,
    input  wire asp_modem_in_t  modem_i,
    output asp_modem_out_t      modem_o,
    output logic                irq_o
);

    asp_state_t s_r;
    asp_state_t s_nxt;

    logic       req;
    logic       wr_done;
    logic       rd_done;
    logic [3:0] idx;
    logic       divisor_select_bit;
    logic       loop;
    logic       sin;
    logic       tx_line;
    logic [2:0] last_bit;
    logic [7:0] len_mask;
    logic [5:0] stop_end;
    logic       tx_par;
    logic       rx_par_ok;
    logic [3:0] mdm_lvl;
    logic [3:0] pend;
    logic [1:0] id_code;
    logic [7:0] irq_source_id;
    logic [7:0] link_status;
    logic [7:0] msr;
    logic [7:0] rd_mux;
    logic [3:0] src;

    // ----------------------------------------
    // Decode and shared terms.
    // ----------------------------------------
    assign idx      = wb_adr_i[5:2];
    assign req      = wb_cyc_i & wb_stb_i;
    assign wr_done  = req & s_r.ack & wb_we_i & wb_sel_i[0];
    assign rd_done  = req & ~s_r.ack & ~wb_we_i;
    assign divisor_select_bit     = s_r.lcr[`ASP_LCR_DIVISOR_SELECT_BIT];
    assign loop     = s_r.mcr[`ASP_MCR_LOOP];
    assign last_bit = 3'h4 + {1'b0, s_r.lcr[1:0]};
    assign len_mask = 8'hff >> (2'h3 - s_r.lcr[1:0]);
    // With STB set, five-bit words get 1.5 stop bits, longer words two; with STB clear, one stop bit.
    assign stop_end = ~s_r.lcr[`ASP_LCR_STB] ? `ASP_TICK_BIT :
                      (s_r.lcr[1:0] == 2'h0) ? `ASP_TICK_ST15 : `ASP_TICK_ST2;
    assign tx_par   = s_r.lcr[`ASP_LCR_STICK] ? ~s_r.lcr[`ASP_LCR_EPS] :
                      ((^s_r.tx_sh) ^ ~s_r.lcr[`ASP_LCR_EPS]);
    assign rx_par_ok = s_r.rx_par == (s_r.lcr[`ASP_LCR_STICK] ? ~s_r.lcr[`ASP_LCR_EPS] :
                       ((^s_r.rx_sh) ^ ~s_r.lcr[`ASP_LCR_EPS]));

    // ----------------------------------------
    // Serial line and modem pins.
    // ----------------------------------------
    always_comb
    begin
        case (s_r.tx_st)
            ASP_STRT: tx_line = 1'b0;
            ASP_DATA: tx_line = s_r.tx_sh[s_r.tx_bit];
            ASP_PAR:  tx_line = tx_par;
            default:  tx_line = 1'b1;
        endcase
    end

    assign sin     = loop ? (tx_line & ~s_r.lcr[`ASP_LCR_BRK]) : s_r.rx_s2;
    assign tx_o    = loop | (tx_line & ~s_r.lcr[`ASP_LCR_BRK]);
    assign modem_o = loop ? 4'hf : ~s_r.mcr[3:0];
    // Levels are active high: dcd, ri, dsr, cts.
    assign mdm_lvl = loop ? {s_r.mcr[3], s_r.mcr[2], s_r.mcr[0], s_r.mcr[1]} : ~s_r.mdm_s2;

    // ----------------------------------------
    // Status words and interrupt priority.
    // ----------------------------------------
    assign link_status  = {1'b0, s_r.tx_holding_empty_flag & (s_r.tx_st == ASP_IDLE), s_r.tx_holding_empty_flag,
                   s_r.bi, s_r.fe, s_r.pe, s_r.oe, s_r.dr};
    assign msr  = {mdm_lvl, s_r.msr_d};
    assign pend = {s_r.irq_enable_mask[3] & (|s_r.msr_d), s_r.irq_enable_mask[1] & s_r.thri,
                   s_r.irq_enable_mask[0] & s_r.dr, s_r.irq_enable_mask[2] & (|link_status[4:1])};

    always_comb
    begin
        if (pend[0])
            id_code = `ASP_ID_LINE;
        else if (pend[1])
            id_code = `ASP_ID_RXD;
        else if (pend[2])
            id_code = `ASP_ID_TX_HOLDING_EMPTY_FLAG;
        else
            id_code = `ASP_ID_MODEM;
    end

    assign irq_source_id   = {5'h00, id_code, ~(|pend)};
    assign src   = {|s_r.msr_d, s_r.tx_holding_empty_flag, |link_status[4:1], s_r.dr};
    assign irq_o = (|pend) | (|(s_r.evt & s_r.evm));

    always_comb
    begin
        case (idx)
            `ASP_IDX_DATA: rd_mux = divisor_select_bit ? s_r.div[7:0] : s_r.receive_buffer;
            `ASP_IDX_IER:  rd_mux = divisor_select_bit ? s_r.div[15:8] : {4'h0, s_r.irq_enable_mask};
            `ASP_IDX_IIR:  rd_mux = irq_source_id;
            `ASP_IDX_LCR:  rd_mux = s_r.lcr;
            `ASP_IDX_MCR:  rd_mux = {3'h0, s_r.mcr};
            `ASP_IDX_LSR:  rd_mux = link_status;
            `ASP_IDX_MSR:  rd_mux = msr;
            `ASP_IDX_SCR:  rd_mux = s_r.scr;
            `ASP_IDX_EVT:  rd_mux = {4'h0, s_r.evt};
            `ASP_IDX_EVM:  rd_mux = {4'h0, s_r.evm};
            default:       rd_mux = 8'h00;
        endcase
    end

    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = {24'h000000, s_r.dat};

    // ----------------------------------------
    // Next state.
    // ----------------------------------------
    always_comb
    begin
        s_nxt = s_r;

        // Bus slave answers one cycle after the request.
        s_nxt.ack = req & ~s_r.ack;
        if (req & ~s_r.ack)
            s_nxt.dat = rd_mux;

        // Input synchronisers.
        s_nxt.rx_s1  = rx_i;
        s_nxt.rx_s2  = s_r.rx_s1;
        s_nxt.mdm_s1 = modem_i;
        s_nxt.mdm_s2 = s_r.mdm_s1;
        s_nxt.mdm_q  = mdm_lvl;

        // Baud generator.
        s_nxt.tick     = (s_r.baud_cnt == s_r.div - 16'h0001);
        s_nxt.baud_cnt = s_nxt.tick ? 16'h0000 : s_r.baud_cnt + 16'h0001;

        // Read side effects at the edge that captures the data, so nothing set later is lost.
        if (rd_done)
        begin
            if (idx == `ASP_IDX_DATA && !divisor_select_bit)
                s_nxt.dr = 1'b0;
            if (idx == `ASP_IDX_IIR && id_code == `ASP_ID_TX_HOLDING_EMPTY_FLAG && pend[2])
                s_nxt.thri = 1'b0;
            if (idx == `ASP_IDX_LSR)
                {s_nxt.bi, s_nxt.fe, s_nxt.pe, s_nxt.oe} = 4'h0;
            if (idx == `ASP_IDX_MSR)
                s_nxt.msr_d = 4'h0;
            if (idx == `ASP_IDX_EVT)
                s_nxt.evt = 4'h0;
        end

        // Register writes.
        if (wr_done)
        begin
            case (idx)
                `ASP_IDX_DATA:
                begin
                    if (divisor_select_bit)
                        s_nxt.div[7:0] = wb_dat_i[7:0];
                    else
                    begin
                        s_nxt.transmit_holding  = wb_dat_i[7:0];
                        s_nxt.tx_holding_empty_flag = 1'b0;
                        s_nxt.thri = 1'b0;
                    end
                end
                `ASP_IDX_IER:
                begin
                    if (divisor_select_bit)
                        s_nxt.div[15:8] = wb_dat_i[7:0];
                    else
                        s_nxt.irq_enable_mask = wb_dat_i[3:0];
                end
                `ASP_IDX_LCR: s_nxt.lcr = wb_dat_i[7:0];
                `ASP_IDX_MCR: s_nxt.mcr = wb_dat_i[4:0];
                `ASP_IDX_SCR: s_nxt.scr = wb_dat_i[7:0];
                `ASP_IDX_EVM: s_nxt.evm = wb_dat_i[3:0];
                default:      s_nxt.scr = s_nxt.scr;
            endcase
        end

        // Modem deltas; trailing edge of ring sets its flag.
        s_nxt.msr_d = s_nxt.msr_d | {s_r.mdm_q[3] ^ mdm_lvl[3], s_r.mdm_q[2] & ~mdm_lvl[2],
                                     s_r.mdm_q[1] ^ mdm_lvl[1], s_r.mdm_q[0] ^ mdm_lvl[0]};

        // Transmitter.
        case (s_r.tx_st)
            ASP_IDLE:
            begin
                if (!s_r.tx_holding_empty_flag)
                begin
                    s_nxt.tx_sh  = s_r.transmit_holding & len_mask;
                    s_nxt.tx_holding_empty_flag   = 1'b1;
                    s_nxt.thri   = 1'b1;
                    s_nxt.tx_cnt = 6'h00;
                    s_nxt.tx_st  = ASP_STRT;
                end
            end
            ASP_STRT, ASP_DATA, ASP_PAR:
            begin
                if (s_r.tick)
                begin
                    s_nxt.tx_cnt = s_r.tx_cnt + 6'h01;
                    if (s_r.tx_cnt == `ASP_TICK_BIT)
                    begin
                        s_nxt.tx_cnt = 6'h00;
                        s_nxt.tx_bit = s_r.tx_bit + 3'h1;
                        if (s_r.tx_st == ASP_STRT)
                        begin
                            s_nxt.tx_bit = 3'h0;
                            s_nxt.tx_st  = ASP_DATA;
                        end
                        else if (s_r.tx_st == ASP_PAR)
                            s_nxt.tx_st = ASP_STOP;
                        else if (s_r.tx_bit == last_bit)
                            s_nxt.tx_st = s_r.lcr[`ASP_LCR_PEN] ? ASP_PAR : ASP_STOP;
                    end
                end
            end
            ASP_STOP:
            begin
                if (s_r.tick)
                begin
                    s_nxt.tx_cnt = s_r.tx_cnt + 6'h01;
                    if (s_r.tx_cnt == stop_end)
                        s_nxt.tx_st = ASP_IDLE;
                end
            end
            default: s_nxt.tx_st = ASP_IDLE;
        endcase

        // Receiver, timed by the same tick.
        case (s_r.rx_st)
            ASP_IDLE:
            begin
                if (!sin)
                begin
                    s_nxt.rx_cnt = 6'h00;
                    s_nxt.rx_st  = ASP_STRT;
                end
            end
            ASP_STRT:
            begin
                if (s_r.tick)
                begin
                    s_nxt.rx_cnt = s_r.rx_cnt + 6'h01;
                    if (s_r.rx_cnt == `ASP_TICK_HALF)
                    begin
                        s_nxt.rx_cnt  = 6'h00;
                        s_nxt.rx_bit  = 3'h0;
                        s_nxt.rx_sh   = 8'h00;
                        s_nxt.rx_zero = 1'b1;
                        s_nxt.rx_st   = sin ? ASP_IDLE : ASP_DATA;
                    end
                end
            end
            ASP_DATA, ASP_PAR, ASP_STOP:
            begin
                if (s_r.tick)
                begin
                    s_nxt.rx_cnt = s_r.rx_cnt + 6'h01;
                    if (s_r.rx_cnt == `ASP_TICK_BIT)
                    begin
                        s_nxt.rx_cnt  = 6'h00;
                        s_nxt.rx_zero = s_r.rx_zero & ~sin;
                        if (s_r.rx_st == ASP_DATA)
                        begin
                            s_nxt.rx_sh[s_r.rx_bit] = sin;
                            s_nxt.rx_bit = s_r.rx_bit + 3'h1;
                            if (s_r.rx_bit == last_bit)
                                s_nxt.rx_st = s_r.lcr[`ASP_LCR_PEN] ? ASP_PAR : ASP_STOP;
                        end
                        else if (s_r.rx_st == ASP_PAR)
                        begin
                            s_nxt.rx_par = sin;
                            s_nxt.rx_st  = ASP_STOP;
                        end
                        else
                        begin
                            s_nxt.receive_buffer   = s_r.rx_sh;
                            s_nxt.oe    = s_r.oe | s_r.dr;
                            s_nxt.dr    = 1'b1;
                            s_nxt.fe    = s_r.fe | ~sin;
                            s_nxt.pe    = s_r.pe | (s_r.lcr[`ASP_LCR_PEN] & ~rx_par_ok);
                            s_nxt.bi    = s_r.bi | (s_r.rx_zero & ~sin);
                            s_nxt.rx_st = ASP_IDLE;
                        end
                    end
                end
            end
            default: s_nxt.rx_st = ASP_IDLE;
        endcase

        // Sticky events on rising sources; set wins over read clear.
        s_nxt.src_q = src;
        s_nxt.evt   = s_nxt.evt | (src & ~s_r.src_q);
    end

    // ----------------------------------------
    // State register.
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_r          <= '0;
            s_r.div      <= `ASP_DIV_RST;
            s_r.lcr      <= `ASP_REG_RST;
            s_r.rx_s1    <= 1'b1;
            s_r.rx_s2    <= 1'b1;
            s_r.mdm_s1   <= 4'hf;
            s_r.mdm_s2   <= 4'hf;
            s_r.tx_holding_empty_flag     <= 1'b1;
            s_r.src_q    <= 4'h2;
            s_r.tx_st    <= ASP_IDLE;
            s_r.rx_st    <= ASP_IDLE;
        end
        else
            s_r <= s_nxt;
    end

    // ----------------------------------------
    // Assertions.
    // ----------------------------------------
    sequence seq_req;
        req && !s_r.ack;
    endsequence
    sequence seq_thr_wr;
        wr_done && idx == `ASP_IDX_DATA && !divisor_select_bit;
    endsequence
    a_ack_timing: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        seq_req |=> s_r.ack ##1 !s_r.ack)
        else $error("ack not one cycle after request");
    a_divisor_select_bit_read: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        seq_req and (idx == `ASP_IDX_DATA && divisor_select_bit && !wb_we_i) |=> wb_dat_o[7:0] == s_r.div[7:0])
        else $error("divisor low byte not returned");
    a_rbr_read: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        seq_req and (idx == `ASP_IDX_DATA && !divisor_select_bit && !wb_we_i) |=> wb_dat_o[7:0] == $past(s_r.receive_buffer))
        else $error("receive buffer not returned");
    a_thr_empty: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        seq_thr_wr |=> !s_r.tx_holding_empty_flag && s_r.transmit_holding == $past(wb_dat_i[7:0]))
        else $error("holding write did not clear empty");
    a_dr_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_done && idx == `ASP_IDX_DATA && !divisor_select_bit && s_r.rx_st != ASP_STOP |=> !s_r.dr)
        else $error("data read did not clear ready");
    a_tick_div2: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        s_r.tick && s_r.div == 16'h0002 && $stable(s_r.div) |=> !s_r.tick ##1 s_r.tick)
        else $error("tick spacing wrong for divisor two");
    a_tx_start: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        s_r.tx_st == ASP_IDLE && !s_r.tx_holding_empty_flag && !loop && !s_r.lcr[`ASP_LCR_BRK] |=> !tx_o)
        else $error("start bit not driven low");
    a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (|pend) |-> irq_o && !irq_source_id[0])
        else $error("pending source without interrupt");
    a_iir_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !(|pend) |-> irq_source_id == 8'h01)
        else $error("identification wrong with nothing pending");
    a_line_prio: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        pend[0] |-> irq_source_id[2:1] == `ASP_ID_LINE)
        else $error("line status not highest priority");
endmodule : asp_serial_port

// File: testbench/asp_term_model.sv
`timescale 1ns/1ns

// ----------------------------------------
// Serial terminal on the far side of the link.
// ----------------------------------------
module asp_term_model #(
    parameter int BIT_CLKS = 32
)(
    input  wire logic       clk_i,
    input  wire logic       line_i,
    output logic            line_o,
    output logic [7:0]      got_o,
    output int              n_got_o
);
    logic [7:0] sh;

    initial
    begin
        line_o  = 1'b1;
        got_o   = 8'h00;
        n_got_o = 0;
    end

    // Start bit, eight data bits LSB first, one stop bit of chosen level.
    task send(input logic [7:0] b, input logic stop);
        logic [9:0] frame;
        frame = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk_i);
            line_o <= frame[i];
            repeat (BIT_CLKS - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        line_o <= 1'b1;
    endtask : send

    // Samples each bit in its middle and stores the byte in the middle of the stop bit.
    always
    begin
        @(negedge line_i);
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CLKS) @(posedge clk_i);
            sh[i] = line_i;
        end
        repeat (BIT_CLKS) @(posedge clk_i);
        got_o   <= sh;
        n_got_o <= n_got_o + 1;
    end
endmodule : asp_term_model

// File: testbench/tb.sv
`timescale 1ns/1ns

module tb
    import asp_pkg::*;
;
    logic           clk_sys_i;
    logic           rst_b_i;
    logic           wb_cyc;
    logic           wb_stb;
    logic           wb_we;
    logic [5:0]     wb_adr;
    logic [3:0]     wb_sel;
    logic [31:0]    wb_dat;
    logic [31:0]    wb_dat_o;
    logic           wb_ack;
    logic           rx_line;
    logic           tx_line;
    asp_modem_in_t  modem_in;
    asp_modem_out_t modem_out;
    logic           irq;
    logic [7:0]     term_got;
    int             term_n;
    int             miscompares;
    int             n_checks;
    int             cycles = 0;

    // Divisor 2 gives 32 clocks per bit.
    asp_serial_port dut_u (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .rx_i(rx_line), .tx_o(tx_line),
        .modem_i(modem_in), .modem_o(modem_out), .irq_o(irq)
    );

    asp_term_model #(.BIT_CLKS(32)) term_u (
        .clk_i(clk_sys_i), .line_i(tx_line), .line_o(rx_line), .got_o(term_got), .n_got_o(term_n)
    );

    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task finish_test();
        $display("Checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // Classic Wishbone single cycle.
    // ----------------------------------------
    task xfer(input logic w, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= {idx, 2'b00};
        wb_dat <= {24'h000000, d};
        @(posedge clk_sys_i);
        while (wb_ack !== 1'b1) @(posedge clk_sys_i);
        q = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : xfer

    task wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, idx, d, q);
    endtask : wr

    task rd(input logic [3:0] idx, input string nm, input logic [7:0] e);
        logic [7:0] q;
        xfer(1'b0, idx, 8'h00, q);
        chk(nm, e, q);
    endtask : rd

    task chk_irq(input logic e);
        @(negedge clk_sys_i);
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask : chk_irq

    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    initial
    begin
        wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 6'h00;
        wb_sel = 4'hf; wb_dat = 32'h00000000; modem_in = 4'hf;
        miscompares = 0; n_checks = 0;
        rst_b_i = 1'b0;
        repeat (5) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd(4'h2, "iir", 8'h01);
        rd(4'h5, "lsr", 8'h60);
        rd(4'h3, "lcr", 8'h00);
        wr(4'h7, 8'ha5);
        rd(4'h7, "scratch", 8'ha5);
        rd(4'ha, "unmapped", 8'h00);
        wr(4'h3, 8'h83);
        wr(4'h0, 8'h02);
        wr(4'h1, 8'h00);
        rd(4'h0, "div_lo", 8'h02);
        rd(4'h1, "div_hi", 8'h00);
        wr(4'h3, 8'h03);
        rd(4'h0, "rbr", 8'h00);
        wr(4'h4, 8'h03);
        @(negedge clk_sys_i);
        chk("modem_o", 8'h0c, {4'h0, modem_out});
        // Transmit one byte and watch the holding flag.
        wr(4'h0, 8'h5a);
        rd(4'h5, "lsr_tx", 8'h20);
        while (term_n < 1) @(posedge clk_sys_i);
        chk("tx_byte", 8'h5a, term_got);
        repeat (40) @(posedge clk_sys_i);
        rd(4'h5, "lsr_idle", 8'h60);
        wr(4'h1, 8'h02);
        chk_irq(1'b1);
        rd(4'h2, "iir_tx_holding_empty_flag", 8'h02);
        chk_irq(1'b0);
        // Receive with data interrupt enabled.
        wr(4'h1, 8'h01);
        term_u.send(8'hc3, 1'b1);
        chk_irq(1'b1);
        rd(4'h2, "iir_rx", 8'h04);
        rd(4'h5, "lsr_rx", 8'h61);
        rd(4'h0, "rbr", 8'hc3);
        rd(4'h5, "lsr_read", 8'h60);
        chk_irq(1'b0);
        // Framing error outranks received data.
        wr(4'h1, 8'h05);
        term_u.send(8'h55, 1'b0);
        rd(4'h2, "iir_line", 8'h06);
        rd(4'h5, "lsr_fe", 8'h69);
        rd(4'h5, "lsr_clr", 8'h61);
        rd(4'h0, "rbr_fe", 8'h55);
        // Masked event register.
        wr(4'h1, 8'h00);
        wr(4'h9, 8'h01);
        rd(4'h8, "evt_pre", 8'h07);
        term_u.send(8'h0f, 1'b1);
        chk_irq(1'b1);
        rd(4'h8, "evt", 8'h01);
        chk_irq(1'b0);
        rd(4'h0, "rbr_evt", 8'h0f);
        // Modem_line_status change.
        wr(4'h1, 8'h08);
        modem_in.cts_n <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk_irq(1'b1);
        rd(4'h2, "iir_modem", 8'h00);
        rd(4'h6, "msr", 8'h11);
        rd(4'h6, "msr_clr", 8'h10);
        chk_irq(1'b0);
        // Loopback: seven data bits with even parity, then an overrun.
        wr(4'h4, 8'h13);
        wr(4'h3, 8'h1a);
        @(negedge clk_sys_i);
        chk("modem_loop", 8'h0f, {4'h0, modem_out});
        wr(4'h0, 8'h35);
        chk("tx_loop", 8'h01, {7'h00, tx_line});
        repeat (400) @(posedge clk_sys_i);
        rd(4'h5, "lsr_loop", 8'h61);
        rd(4'h0, "rbr_loop", 8'h35);
        wr(4'h0, 8'h4a);
        wr(4'h0, 8'h21);
        repeat (720) @(posedge clk_sys_i);
        rd(4'h5, "lsr_ovr", 8'h63);
        rd(4'h0, "rbr_ovr", 8'h21);
        finish_test();
    end
endmodule : tb
